/* logic/portb_pinmux.sv */
// per-pin output priority mux and driver enables
// assumes registered controls; output is registered here
`timescale 1ns/1ns
module portb_pinmux
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic [7:0]           i_latch,
    input  wire logic [7:0]           i_direction,
    input  wire portb_pkg::alt_out_t  i_alt,
    output portb_pkg::pad_out_t       o_pad
);
    typedef struct packed {
        portb_pkg::pad_out_t pad;
    } mux_st_t;

    mux_st_t st_r;
    mux_st_t st_nxt;

    // per pin: alternate function beats the latch; analog select is not looked at
    always_comb
    begin
        st_nxt = st_r;
        for (int i = 0; i < 8; i++)
        begin
            logic lvl;
            lvl = (i_alt.en[i] & portb_pkg::ALT_MASK[i]) ? i_alt.val[i]
                                                         : i_latch[i];
            if (!portb_pkg::PIN_MASK[i] || i_direction[i])
            begin
                st_nxt.pad.o[i]  = 1'b0;
                st_nxt.pad.oe[i] = 1'b0;
            end
            else if (i == portb_pkg::OD_PIN)
            begin
                st_nxt.pad.o[i]  = 1'b0;
                st_nxt.pad.oe[i] = ~lvl;
            end
            else
            begin
                st_nxt.pad.o[i]  = lvl;
                st_nxt.pad.oe[i] = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_pad = st_r.pad;
endmodule : portb_pinmux

/* logic/portb_sync.sv */
// three-flop synchroniser for the port pin levels
// assumes pins are asynchronous to i_mclk
`timescale 1ns/1ns
module portb_sync
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_async,
    output logic      [7:0] o_level
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] lvl;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    // shift chain; the level changes only once stages two and three agree
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.s1  = i_async;
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_level = st_r.lvl;
endmodule : portb_sync

/* logic/portb_top.sv */
// port b gpio: axi4-lite registers, pin sampling, output mux
// assumes external pad cells resolve o_pad_o/o_pad_oe/i_pad_i per pin
// Behaviour
// - pin 0 only pulls low, never high
// - highest priority enabled function owns the pin
// - latch lowest, alternate function highest per pin
// - analog functions enabled only in analog mode
// - digital outputs still drive analog-mode pins
// - data read returns pin levels
// - bits 3 and 2 read zero
// - direction one disables the driver
// - direction zero enables the driver of implemented pins, on pin 0 only while its output level is low
// - data write updates latch, read returns pins
// - analog-select pins read zero
`timescale 1ns/1ns
module portb_top
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_arst_n,
    // axi4-lite slave
    input  wire logic [7:0]           i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [7:0]           i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    // peripherals
    input  wire logic [7:0]           i_alt_val,
    // pads
    input  wire logic [7:0]           i_pad_i,
    output logic      [7:0]           o_pad_o,
    output logic      [7:0]           o_pad_oe,
    // analog function enables per pin
    output logic      [7:0]           o_analog_en
);
    // register, bus and output flop state of the block, registered as one word
    typedef struct packed {
        // software registers
        logic [7:0]  latch;
        logic [7:0]  direction;
        logic [7:0]  analog;
        logic [7:0]  alt_en;
        // write channel
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        // read channel
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // output flops towards pads and analog cells
        logic [7:0]  ana_en;
        logic [7:0]  pad_o;
        logic [7:0]  pad_oe;
    } top_st_t;

    // state copy, synchronised pin levels and mux carriers
    top_st_t             st_r;
    top_st_t             st_nxt;
    logic                rst_q1;
    logic                rst_n;
    logic [7:0]          pin_lvl;
    portb_pkg::alt_out_t alt;
    portb_pkg::pad_out_t pad;

    // reset release through two flops; assertion acts at once,
    // release reaches the rest of the block two edges later
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // pin level sampling
    portb_sync u_sync
    (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n),
        .i_async (i_pad_i),
        .o_level (pin_lvl)
    );

    // alternate function requests: enables from software, levels from peripherals
    assign alt.en  = st_r.alt_en;
    assign alt.val = i_alt_val;

    // output priority mux
    portb_pinmux u_mux
    (
        .i_mclk      (i_mclk),
        .i_rst_n     (rst_n),
        .i_latch     (st_r.latch),
        .i_direction (st_r.direction),
        .i_alt       (alt),
        .o_pad       (pad)
    );

    // register file and axi4-lite handshakes
    always_comb
    begin
        logic [7:0] wa;
        logic [7:0] ra;
        logic       wr_fire;
        logic       rd_fire;
        logic [7:0] rd_byte;
        logic [1:0] rd_resp;
        wa      = '0;
        ra      = '0;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        rd_byte = '0;
        rd_resp = portb_pkg::RESP_OKAY;
        st_nxt  = st_r;

        // pad drive passes one more flop so the outputs leave a register
        st_nxt.pad_o  = pad.o;
        st_nxt.pad_oe = pad.oe;
        // analog functions follow the select bits of implemented pins only
        st_nxt.ana_en = st_r.analog & portb_pkg::PIN_MASK;

        // address half of a write, taken while awready stands
        if (i_awvalid && st_r.awready)
        begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = i_awaddr;
        end
        // data half of a write, taken while wready stands; lane zero only
        if (i_wvalid && st_r.wready)
        begin
            st_nxt.w_got   = 1'b1;
            st_nxt.w_data  = i_wdata[7:0];
            st_nxt.w_strb0 = i_wstrb[0];
        end

        // commit the write once both halves are held and no response pends
        wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        if (wr_fire)
        begin
            wa            = {st_r.aw_addr[7:2], 2'b00};
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = portb_pkg::RESP_OKAY;
            case (wa)
                portb_pkg::OFS_DATA:
                begin
                    // only the latch takes the write; reads show the pins
                    if (st_r.w_strb0)
                    begin
                        st_nxt.latch = st_r.w_data & portb_pkg::PIN_MASK;
                    end
                end
                portb_pkg::OFS_DIRECTION:
                begin
                    // absent pins keep their bits at zero
                    if (st_r.w_strb0)
                    begin
                        st_nxt.direction = st_r.w_data & portb_pkg::PIN_MASK;
                    end
                end
                portb_pkg::OFS_ANALOG:
                begin
                    if (st_r.w_strb0)
                    begin
                        st_nxt.analog = st_r.w_data & portb_pkg::PIN_MASK;
                    end
                end
                portb_pkg::OFS_ALT_EN:
                begin
                    // only pins with an alternate function keep an enable
                    if (st_r.w_strb0)
                    begin
                        st_nxt.alt_en = st_r.w_data & portb_pkg::ALT_MASK;
                    end
                end
                default:
                begin
                    // unmapped word: error answer, nothing changes
                    st_nxt.bresp = portb_pkg::RESP_SLVERR;
                end
            endcase
        end
        // the write response stands until the master takes it
        if (st_r.bvalid && i_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // read: taken when no read data is outstanding; data stand until taken
        rd_fire = i_arvalid && st_r.arready;
        if (rd_fire)
        begin
            ra = {i_araddr[7:2], 2'b00};
            case (ra)
                portb_pkg::OFS_DATA:
                begin
                    // synchronised pin levels; analog and absent pins read zero
                    rd_byte = pin_lvl & ~st_r.analog
                              & portb_pkg::PIN_MASK;
                end
                portb_pkg::OFS_DIRECTION:
                begin
                    rd_byte = st_r.direction & portb_pkg::PIN_MASK;
                end
                portb_pkg::OFS_ANALOG:
                begin
                    rd_byte = st_r.analog;
                end
                portb_pkg::OFS_ALT_EN:
                begin
                    rd_byte = st_r.alt_en;
                end
                default:
                begin
                    // unmapped word: error answer with zero data
                    rd_resp = portb_pkg::RESP_SLVERR;
                end
            endcase
            // one answer per read; bits above the byte read zero
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = rd_resp;
            st_nxt.rdata  = {24'h0, rd_byte};
        end
        else if (st_r.rvalid && i_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // ready flags leave a register: low while a half is held or read data stand
        st_nxt.awready = ~st_nxt.aw_got;
        st_nxt.wready  = ~st_nxt.w_got;
        st_nxt.arready = ~st_nxt.rvalid;
    end

    // state register
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // bus idle; nothing is taken until the release has passed both flops
            st_r           <= '0;
            st_r.awready   <= 1'b0;
            st_r.wready    <= 1'b0;
            st_r.arready   <= 1'b0;
            // software registers at their reset values; pads undriven
            st_r.latch     <= portb_pkg::RST_DATA;
            st_r.direction <= portb_pkg::RST_DIRECTION;
            st_r.analog    <= portb_pkg::RST_ANALOG;
            st_r.alt_en    <= portb_pkg::RST_ALT_EN;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // write channel outputs, straight from flops
    assign o_awready   = st_r.awready;
    assign o_wready    = st_r.wready;
    assign o_bvalid    = st_r.bvalid;
    assign o_bresp     = st_r.bresp;

    // read channel outputs, straight from flops
    assign o_arready   = st_r.arready;
    assign o_rvalid    = st_r.rvalid;
    assign o_rdata     = st_r.rdata;
    assign o_rresp     = st_r.rresp;

    // pad and analog outputs, straight from flops
    assign o_pad_o     = st_r.pad_o;
    assign o_pad_oe    = st_r.pad_oe;
    assign o_analog_en = st_r.ana_en;
endmodule : portb_top

/* shared/portb_pkg.sv */
// port b constants, register map and carrier structs
// assumes a 32-bit axi4-lite register bus and 8-bit port registers
package portb_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA      = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_ANALOG    = 8'h08;
    localparam logic [7:0] OFS_ALT_EN    = 8'h0c;
    // implemented pins of the port
    localparam logic [7:0] PIN_MASK      = 8'hf3;
    // alternate function mask: pins 0, 1, 4, 7
    localparam logic [7:0] ALT_MASK      = 8'h93;
    // reset values
    localparam logic [7:0] RST_DATA      = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hf3;
    localparam logic [7:0] RST_ANALOG    = 8'h72;
    localparam logic [7:0] RST_ALT_EN    = 8'h00;
    // open-drain pin position
    localparam int         OD_PIN        = 0;
    // axi response codes
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // per-pin alternate function drive: enables from software, levels from the peripherals
    typedef struct packed {
        logic [7:0] en;   // alternate function wants the pin
        logic [7:0] val;  // level the alternate function drives
    } alt_out_t;

    // pin drive towards the pads
    typedef struct packed {
        logic [7:0] o;    // output level
        logic [7:0] oe;   // output enable, high while driving
    } pad_out_t;
endpackage : portb_pkg

/* verif/port_b_pin_mux_and_direction_test.sv */
// self-checking bench for port b
// assumes portb_top, the board model and the checker bind
`timescale 1ns/1ns
module port_b_pin_mux_and_direction_test;
    logic        i_mclk, i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0]  i_awaddr, i_araddr, i_alt_val, i_pad_i, o_pad_o, o_pad_oe, o_analog_en;
    logic [7:0]  lvl, dir, an, alt, lat, eoe, eo;
    logic [31:0] i_wdata, o_rdata, rdv;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, rsp;
    int          fails, n_compared;
    portb_top DUT (.*);
    portb_board u_board (.i_pad_o(o_pad_o), .i_pad_oe(o_pad_oe), .i_lvl(lvl), .o_pad(i_pad_i));
    // clock
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic end_sim();
        $display("fails=%0d compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic guard(input logic busy);
        if (busy)
        begin
            fails++;
            end_sim();
        end
    endtask : guard
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge i_mclk);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, 24'h0, d, 3'h7};
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
            if (o_bvalid)
            begin
                rsp      = o_bresp;
                done     = 1'b1;
                i_bready <= 1'b0;
            end
        end
        guard(!done);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge i_mclk);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge i_mclk);
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
            if (o_rvalid)
            begin
                {rsp, rdv} = {o_rresp, o_rdata};
                done       = 1'b1;
                i_rready   <= 1'b0;
            end
        end
        guard(!done);
    endtask : rd
    // expected pad drive {oe, o} from latch, direction, enables and alt levels
    function automatic logic [15:0] pads(input logic [7:0] la, di, ae, av);
        logic [7:0] v, oe;
        v = (ae & portb_pkg::ALT_MASK & av) | (~(ae & portb_pkg::ALT_MASK) & la);
        oe = ~di & portb_pkg::PIN_MASK;
        oe[0] = oe[0] & ~v[0];
        v[0] = 1'b0;
        return {oe, v & oe};
    endfunction : pads
    // reset, reset values, unmapped address, then random configurations
    initial
    begin
        {i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h0;
        {i_awaddr, i_araddr, i_wdata, i_alt_val, lvl, i_wstrb} = {64'h0, 4'h1};
        {fails, n_compared} = 64'h0;
        rdv = $urandom(32'h47ef);
        repeat (6) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        rd(portb_pkg::OFS_DIRECTION);
        cmp(rdv, {24'h0, portb_pkg::RST_DIRECTION});
        rd(portb_pkg::OFS_ANALOG);
        cmp(rdv, {24'h0, portb_pkg::RST_ANALOG});
        cmp({24'h0, o_pad_oe}, 32'h0);
        rd(8'h10);
        cmp({30'h0, rsp}, {30'h0, portb_pkg::RESP_SLVERR});
        wr(8'h10, 8'hff);
        cmp({30'h0, rsp}, {30'h0, portb_pkg::RESP_SLVERR});
        for (int k = 0; k < 40; k++)
        begin
            {lat, dir, an, alt} = $urandom;
            an = an & portb_pkg::PIN_MASK;
            if (k < 2)
                {dir, an, alt} = {8'h00, k == 0 ? 16'h72ff : 16'h0000};
            wr(portb_pkg::OFS_DATA, lat);
            wr(portb_pkg::OFS_DIRECTION, dir);
            wr(portb_pkg::OFS_ANALOG, an);
            wr(portb_pkg::OFS_ALT_EN, alt);
            {i_alt_val, lvl} <= 16'($urandom);
            repeat (10) @(posedge i_mclk);
            {eoe, eo} = pads(lat, dir, alt, i_alt_val);
            cmp({24'h0, o_pad_oe}, {24'h0, eoe});
            cmp({24'h0, o_pad_o & eoe}, {24'h0, eo});
            cmp({24'h0, o_analog_en}, {24'h0, an});
            rd(portb_pkg::OFS_DATA);
            cmp(rdv, {24'h0, (eo | (~eoe & lvl)) & ~an & portb_pkg::PIN_MASK});
            cmp({30'h0, rsp}, {30'h0, portb_pkg::RESP_OKAY});
            rd(portb_pkg::OFS_DIRECTION);
            cmp(rdv, {24'h0, dir & portb_pkg::PIN_MASK});
        end
        // mid-run reset: pads released, registers back at their reset values
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        cmp({24'h0, o_pad_oe}, 32'h0);
        cmp({24'h0, o_analog_en}, {24'h0, portb_pkg::RST_ANALOG & portb_pkg::PIN_MASK});
        // a write with byte lane zero off leaves the direction register alone
        i_wstrb <= 4'h0;
        wr(portb_pkg::OFS_DIRECTION, 8'h00);
        i_wstrb <= 4'h1;
        rd(portb_pkg::OFS_DIRECTION);
        cmp(rdv, {24'h0, portb_pkg::RST_DIRECTION});
        end_sim();
    end
endmodule : port_b_pin_mux_and_direction_test

/* verif/portb_board.sv */
// board model on the port b pads
// assumes oe high means the device drives the pad
`timescale 1ns/1ns
module portb_board
(
    input  wire logic [7:0] i_pad_o,
    input  wire logic [7:0] i_pad_oe,
    input  wire logic [7:0] i_lvl,
    output logic      [7:0] o_pad
);
    // device drive wins; pin 0 can only sink, else the board level shows
    always_comb
        for (int i = 0; i < 8; i++)
            o_pad[i] = i_pad_oe[i] ? (i != 0) & i_pad_o[i] : i_lvl[i];
endmodule : portb_board

/* verif/portb_top_chk.sv */
// port-level checks of the port b block
// assumes it is bound into portb_top
`timescale 1ns/1ns
module portb_top_chk
(
    input wire logic        i_mclk,
    input wire logic        i_arst_n,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [7:0]  o_pad_o,
    input wire logic [7:0]  o_pad_oe,
    input wire logic [7:0]  o_analog_en
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // pin rules and register bus rules
    property p_od; o_pad_o[0] == 1'b0; endproperty
    a_od: assert property (p_od) else $error("pin 0 driven high");
    property p_oe_gap; o_pad_oe[3:2] == 2'h0; endproperty
    a_oe_gap: assert property (p_oe_gap) else $error("absent pin driven");
    property p_an; (o_analog_en & 8'h0c) == 8'h00; endproperty
    a_an: assert property (p_an) else $error("analog on absent pin");
    property p_rd0; o_rvalid |-> o_rdata[3:2] == 2'h0 && o_rdata[31:8] == 24'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("read bits not zero");
    property p_rd; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_wr; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response moved");
    property p_arblk; o_rvalid |-> !o_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while busy");
    // main scenarios reached
    c_wr: cover property (o_bvalid && i_bready);
    c_rd: cover property (o_rvalid && i_rready);
    c_sink: cover property (o_pad_oe[0]);
endmodule : portb_top_chk
bind portb_top portb_top_chk u_chk (.*);
